// [hdl/php_decoder.sv]
// decode and execute for or-tail, pack halfword and preload hints
//
// Behaviour
// - or result, flags n z c, v kept
// - pack with flag or high bit is undefined
// - pack undefined without signal-processing extension
// - order bit picks lsl/bottom or asr/top
// - top-first zero shift field means asr 32
// - pack registers 13 or 15 unpredictable
// - halfword placement per pack variant
// - 12-bit data offset zero-extended and added
// - 8-bit offset zero-extended and subtracted
// - data base 1111 decodes as literal form
// - literal base is pc aligned down to 4
// - literal direction bit one adds, zero subtracts
// - index shifted left 0..3, added to base
// - index register 13 or 15 unpredictable
// - preloads undefined without main extension
// - data preload only signals address as hint
// - instruction preload 1111 goes literal, else add, subtract or index as for data
`timescale 1ns/1ps
`default_nettype none
module php_decoder
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,

  // instruction issue
  input  wire logic        INSTR_VALID,
  input  wire logic [31:0] INSTR_WORD,
  input  wire logic [31:0] PC_VALUE,
  input  wire logic [31:0] FIRST_SOURCE_VALUE,
  input  wire logic [31:0] SECOND_SOURCE_VALUE,
  input  wire logic        FLAG_C_IN,

  // implemented extensions
  input  wire logic        HAVE_MAIN_EXT,
  input  wire logic        HAVE_DSP_EXT,

  // register write-back
  output logic             RESULT_VALID,
  output logic      [3:0]  RESULT_DEST,
  output logic      [31:0] RESULT_DATA,

  // program flags word update
  output logic             FLAGS_WRITE,
  output logic             FLAG_N,
  output logic             FLAG_Z,
  output logic             FLAG_C,

  // decode status
  output logic             CLAIMED,
  output logic             UNDEFINED,
  output logic             UNPREDICTABLE,

  // preload hint towards the memory system
  output logic             DATA_HINT_VALID,
  output logic             INSTR_HINT_VALID,
  output logic      [31:0] HINT_ADDR,
  input  wire logic        HINT_READY
);
  // instruction fields
  logic [15:0] hw1;                 // first halfword
  logic [15:0] hw2;                 // second halfword
  logic [3:0]  first_source_field;  // base or first source register
  logic [3:0]  second_source_field; // second source or index register
  logic [3:0]  dest_field;          // destination register
  logic [2:0]  shift_high_field;    // upper shift bits
  logic [1:0]  shift_low_field;     // lower shift bits
  logic [1:0]  index_shift;         // index shift 0..3
  logic [1:0]  type_field;          // shift kind of the or form
  logic        halfword_order_select;
  logic        flag_bit;            // flag update / pack s bit
  logic        pack_high_bit;       // pack bit that must be zero
  logic [11:0] twelve_bit_offset;
  logic [7:0]  eight_bit_offset;
  logic [4:0]  imm5;                // joined shift field

  // field slices
  assign hw1                   = INSTR_WORD[31:php_pkg::HW1_LSB];
  assign hw2                   = INSTR_WORD[15:0];
  assign first_source_field    = hw1[3:0];
  assign second_source_field   = hw2[3:0];
  assign dest_field            = hw2[11:8];
  assign shift_high_field      = hw2[14:12];
  assign shift_low_field       = hw2[7:6];
  assign index_shift           = hw2[5:4];
  assign type_field            = hw2[5:4];
  assign halfword_order_select = hw2[5];
  assign pack_high_bit         = hw2[4];
  assign flag_bit              = hw1[4];
  assign twelve_bit_offset     = hw2[11:0];
  assign eight_bit_offset      = hw2[7:0];
  assign imm5                  = {shift_high_field, shift_low_field};

  // register number is the stack pointer or the program counter
  function automatic logic bad_reg(input logic [3:0] r);
    bad_reg = (r == php_pkg::REG_SP) || (r == php_pkg::REG_PC);
  endfunction

  // opcode matches
  logic base_is_pc;   // base field 1111
  logic is_or;        // or form, base not 1111
  logic is_pack;      // pack halfword pair
  logic is_dpl_pos;   // data preload, 12-bit add
  logic is_dpl_neg;   // data preload, 8-bit subtract
  logic is_dpl_idx;   // data preload, shifted index
  logic is_dpl_lit;   // data preload, literal
  logic is_ipl_pos;   // instruction preload, 12-bit add
  logic is_ipl_neg;   // instruction preload, 8-bit subtract
  logic is_ipl_idx;   // instruction preload, shifted index
  logic is_ipl_lit;   // instruction preload, literal
  logic is_data;      // any data preload
  logic is_ins;       // any instruction preload
  logic is_hint;      // any preload
  logic lit_dir;      // literal direction bit

  // form matches
  assign base_is_pc = (first_source_field == php_pkg::REG_PC);
  assign lit_dir    = hw1[php_pkg::LIT_DIR_BIT];
  assign is_or      = (hw1[15:5] == php_pkg::OP_OR_REG) && !base_is_pc;
  assign is_pack    = (hw1[15:5] == php_pkg::OP_PACK);

  // base 1111 on a data form is the literal form instead
  assign is_dpl_lit = ((hw1 & php_pkg::LIT_MASK) == php_pkg::LIT_DATA)
                      && (hw2[15:12] == php_pkg::HW2_TWELVE_BIT_OFFSET);
  assign is_dpl_pos = (hw1[15:4] == php_pkg::OP_DPL_POS) && !base_is_pc
                      && (hw2[15:12] == php_pkg::HW2_TWELVE_BIT_OFFSET);
  assign is_dpl_neg = (hw1[15:4] == php_pkg::OP_DPL_NEG) && !base_is_pc
                      && (hw2[15:8] == php_pkg::HW2_EIGHT_BIT_OFFSET);
  assign is_dpl_idx = (hw1[15:4] == php_pkg::OP_DPL_NEG) && !base_is_pc
                      && (hw2[15:6] == php_pkg::HW2_INDEX);

  // instruction preload with base 1111 goes to the literal form
  assign is_ipl_lit = ((hw1 & php_pkg::LIT_MASK) == php_pkg::LIT_INSTR)
                      && (hw2[15:12] == php_pkg::HW2_TWELVE_BIT_OFFSET);
  assign is_ipl_pos = (hw1[15:4] == php_pkg::OP_IPL_POS) && !base_is_pc
                      && (hw2[15:12] == php_pkg::HW2_TWELVE_BIT_OFFSET);
  assign is_ipl_neg = (hw1[15:4] == php_pkg::OP_IPL_NEG) && !base_is_pc
                      && (hw2[15:8] == php_pkg::HW2_EIGHT_BIT_OFFSET);
  assign is_ipl_idx = (hw1[15:4] == php_pkg::OP_IPL_NEG) && !base_is_pc
                      && (hw2[15:6] == php_pkg::HW2_INDEX);
  // per-kind unions
  assign is_data    = is_dpl_lit | is_dpl_pos | is_dpl_neg | is_dpl_idx;
  assign is_ins     = is_ipl_lit | is_ipl_pos | is_ipl_neg | is_ipl_idx;
  assign is_hint    = is_data | is_ins;

  // undefined and unpredictable conditions
  logic pack_undef;  // pack refused
  logic or_undef;    // or form refused
  logic hint_undef;  // preload refused
  logic undef_w;     // any refusal
  logic unpred_w;    // any unpredictable register choice
  logic claimed_w;   // encoding belongs to this block

  // refusals
  assign pack_undef = is_pack && (flag_bit || pack_high_bit);
  assign or_undef   = is_or && !HAVE_MAIN_EXT;
  assign hint_undef = is_hint && !HAVE_MAIN_EXT;
  assign undef_w    = pack_undef || (is_pack && !HAVE_DSP_EXT)
                      || or_undef || hint_undef;
  assign unpred_w   = (is_pack && (bad_reg(dest_field) || bad_reg(first_source_field)
                       || bad_reg(second_source_field)))
                      || (is_or && (bad_reg(dest_field)
                       || (first_source_field == php_pkg::REG_SP)
                       || bad_reg(second_source_field)))
                      || ((is_dpl_idx || is_ipl_idx)
                       && bad_reg(second_source_field));
  assign claimed_w  = is_or || is_pack || is_hint;

  // shift decode for the or and pack forms
  logic [1:0] sh_kind;    // effective shift kind
  logic [5:0] sh_amount;  // effective amount 0..32
  logic       sh_rrx;     // rotate with extend
  logic [31:0] shifted;   // shifted second operand
  logic        sh_carry;  // shifter carry out

  // pack uses kind order:0, or uses its own type field
  assign sh_kind   = is_pack ? {halfword_order_select, 1'b0} : type_field;

  // zero field on lsr or asr means 32, on lsl means none, on ror it selects rrx
  assign sh_amount = ((imm5 == 5'h00) && sh_kind[1] != sh_kind[0] && sh_kind != php_pkg::SH_LSL)
                     ? php_pkg::SH_FULL : {1'b0, imm5};
  assign sh_rrx    = (sh_kind == php_pkg::SH_ROR) && (imm5 == 5'h00);

  // shared shift unit
  php_shifter u_shifter
  (
    .value     (SECOND_SOURCE_VALUE),
    .kind      (sh_kind),
    .amount    (sh_amount),
    .rrx       (sh_rrx),
    .carry_in  (FLAG_C_IN),
    .result    (shifted),
    .carry_out (sh_carry)
  );

  // or result and pack result
  logic [31:0] or_result;    // or of first source and shifted
  logic [31:0] pack_result;  // halfwords joined

  assign or_result   = FIRST_SOURCE_VALUE | shifted;

  // top-first: low from shifted, high from first source
  assign pack_result = halfword_order_select
                       ? {FIRST_SOURCE_VALUE[31:16], shifted[15:0]}
                       : {shifted[31:16], FIRST_SOURCE_VALUE[15:0]};

  // preload address operands
  logic [31:0] aligned_pc;  // pc rounded down to a word
  logic [31:0] hint_base;   // base for the hint
  logic [31:0] hint_off;    // zero-extended offset
  logic        hint_add;    // add or subtract
  logic [31:0] hint_addr_w; // computed hint address
  logic        is_lit;      // either literal form
  logic        is_idx;      // either index form
  logic        is_neg;      // either 8-bit subtract form

  // form groups
  assign is_lit     = is_dpl_lit || is_ipl_lit;
  assign is_idx     = is_dpl_idx || is_ipl_idx;
  assign is_neg     = is_dpl_neg || is_ipl_neg;
  assign aligned_pc = {PC_VALUE[31:2], 2'b00};
  assign hint_base  = is_lit ? aligned_pc : FIRST_SOURCE_VALUE;

  // index shifted by 0..3, 8-bit and 12-bit offsets zero-extended
  assign hint_off   = is_idx ? 32'(SECOND_SOURCE_VALUE << index_shift)
                      : is_neg ? {24'h000000, eight_bit_offset}
                      : {20'h00000, twelve_bit_offset};

  // literal direction bit, others fixed by form
  assign hint_add   = is_lit ? lit_dir : !is_neg;

  // hint address adder
  php_hint_addr u_hint_addr
  (
    .base   (hint_base),
    .offset (hint_off),
    .add    (hint_add),
    .addr   (hint_addr_w)
  );

  // next-state decisions
  logic go;          // accepted, defined instruction this cycle
  logic do_or;       // or executes
  logic do_pack;     // pack executes
  logic do_dhint;    // data hint issues
  logic do_ihint;    // instruction hint issues
  logic hint_busy;   // a hint still waits for the memory system
  logic hint_taken;  // memory system takes the pending hint

  // execute and handshake
  assign go         = INSTR_VALID && claimed_w && !undef_w;
  assign do_or      = go && is_or;
  assign do_pack    = go && is_pack;
  assign do_dhint   = go && is_data;
  assign do_ihint   = go && is_ins;
  // hint port state
  assign hint_busy  = DATA_HINT_VALID || INSTR_HINT_VALID;
  assign hint_taken = hint_busy && HINT_READY;

  // write-back port, one cycle per executed or and pack
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      RESULT_VALID <= 1'b0;
      RESULT_DEST  <= php_pkg::RST_REG;
      RESULT_DATA  <= php_pkg::RST_WORD;
    end
    else
    begin
      // one-cycle pulse
      RESULT_VALID <= do_or || do_pack;
      if (do_or || do_pack)
      begin
        RESULT_DEST <= dest_field;
        RESULT_DATA <= do_pack ? pack_result : or_result;
      end
    end
  end

  // flags: only or with flag bit writes them, pack never
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      FLAGS_WRITE <= 1'b0;
      FLAG_N      <= 1'b0;
      FLAG_Z      <= 1'b0;
      FLAG_C      <= 1'b0;
    end
    else
    begin
      FLAGS_WRITE <= do_or && flag_bit;
      if (do_or && flag_bit)
      begin
        FLAG_N <= or_result[31];
        FLAG_Z <= (or_result == php_pkg::RST_WORD);
        FLAG_C <= sh_carry;
      end
    end
  end

  // decode status, one cycle per issued instruction
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      CLAIMED       <= 1'b0;
      UNDEFINED     <= 1'b0;
      UNPREDICTABLE <= 1'b0;
    end
    else
    begin
      // one-cycle pulses
      CLAIMED       <= INSTR_VALID && claimed_w;
      UNDEFINED     <= INSTR_VALID && claimed_w && undef_w;
      UNPREDICTABLE <= go && unpred_w;
    end
  end

  // hint port: held until taken; a newer hint replaces an old one
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      DATA_HINT_VALID  <= 1'b0;
      INSTR_HINT_VALID <= 1'b0;
      HINT_ADDR        <= php_pkg::RST_WORD;
    end
    else if (do_dhint || do_ihint)
    begin
      // address only, no fault and no register change
      DATA_HINT_VALID  <= do_dhint;
      INSTR_HINT_VALID <= do_ihint;
      HINT_ADDR        <= hint_addr_w;
    end
    else if (hint_taken)
    begin
      // memory system takes or drops it, no answer back
      DATA_HINT_VALID  <= 1'b0;
      INSTR_HINT_VALID <= 1'b0;
    end
  end
endmodule // php_decoder
`default_nettype wire

// [hdl/php_pkg.sv]
// shared constants for the pack, or-tail and preload-hint decoder
package php_pkg;
  // instruction word: first halfword in [31:16], second in [15:0]
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned HW1_LSB      = 16;
  // first-halfword opcode patterns, top 11 bits (bit 4 is the flag bit)
  localparam logic [10:0] OP_OR_REG    = 11'h752;  // 11101010010
  localparam logic [10:0] OP_PACK      = 11'h756;  // 11101010110
  // first-halfword opcode patterns, top 12 bits (base field below)
  localparam logic [11:0] OP_DPL_POS   = 12'hf89;  // data, 12-bit add
  localparam logic [11:0] OP_DPL_NEG   = 12'hf81;  // data, 8-bit sub / index
  localparam logic [11:0] OP_IPL_POS   = 12'hf99;  // instruction, 12-bit add
  localparam logic [11:0] OP_IPL_NEG   = 12'hf91;  // instruction, 8-bit sub / index
  // literal forms: first halfword with the direction bit masked off
  localparam logic [15:0] LIT_DATA     = 16'hf81f;
  localparam logic [15:0] LIT_INSTR    = 16'hf91f;
  localparam logic [15:0] LIT_MASK     = 16'hff7f;
  localparam int unsigned LIT_DIR_BIT  = 7;
  // second-halfword patterns of the preload forms
  localparam logic [3:0]  HW2_TWELVE_BIT_OFFSET    = 4'hf;     // bits 15:12
  localparam logic [7:0]  HW2_EIGHT_BIT_OFFSET     = 8'hfc;    // bits 15:8
  localparam logic [9:0]  HW2_INDEX    = 10'h3c0;  // bits 15:6
  // register numbers that make an encoding unpredictable
  localparam logic [3:0]  REG_SP       = 4'hd;
  localparam logic [3:0]  REG_PC       = 4'hf;
  // shift kinds and the shift that a zero top-first field stands for
  localparam logic [1:0]  SH_LSL       = 2'h0;
  localparam logic [1:0]  SH_LSR       = 2'h1;
  localparam logic [1:0]  SH_ASR       = 2'h2;
  localparam logic [1:0]  SH_ROR       = 2'h3;
  localparam logic [5:0]  SH_FULL      = 6'h20;
  // reset values
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [3:0]  RST_REG      = 4'h0;
endpackage : php_pkg

// [hdl/php_shifter.sv]
// immediate-shift unit with carry out, used by or-tail and pack
`timescale 1ns/1ps
`default_nettype none
module php_shifter
(
  // operand in
  input  wire logic [31:0] value,
  input  wire logic [1:0]  kind,
  input  wire logic [5:0]  amount,
  input  wire logic        rrx,
  input  wire logic        carry_in,
  // shifted result
  output logic      [31:0] result,
  output logic             carry_out
);
  logic [32:0] lsl_w;    // carry:result for left shift
  logic [32:0] lsr_w;    // result:carry for logical right
  logic [32:0] asr_w;    // result:carry for arithmetic right
  logic [31:0] ror_w;    // rotated value
  logic [5:0]  inv_w;    // complementary rotate amount

  // all candidate shifts side by side
  assign lsl_w = {1'b0, value} << amount;
  assign lsr_w = {value, 1'b0} >> amount;
  assign asr_w = 33'($signed({value, 1'b0}) >>> amount);
  assign inv_w = 6'(php_pkg::SH_FULL - amount);
  assign ror_w = (value >> amount) | (value << inv_w);

  // rrx first, else pick by kind; zero amount without rrx passes value and carry through
  always_comb
  begin
    result    = value;
    carry_out = carry_in;
    if (rrx)
    begin
      result    = {carry_in, value[31:1]};
      carry_out = value[0];
    end
    else if (amount != 6'h00)
    begin
      case (kind)
        php_pkg::SH_LSL:
        begin
          result    = lsl_w[31:0];
          carry_out = lsl_w[32];
        end
        php_pkg::SH_LSR:
        begin
          result    = lsr_w[32:1];
          carry_out = lsr_w[0];
        end
        php_pkg::SH_ASR:
        begin
          result    = asr_w[32:1];
          carry_out = asr_w[0];
        end
        default:
        begin
          result    = ror_w;
          carry_out = ror_w[31];
        end
      endcase
    end
  end
endmodule // php_shifter
`default_nettype wire

// [hdl/php_hint_addr.sv]
// base plus or minus offset for preload hint addresses
`timescale 1ns/1ps
`default_nettype none
module php_hint_addr
(
  // operands
  input  wire logic [31:0] base,
  input  wire logic [31:0] offset,
  input  wire logic        add,
  // address out
  output logic      [31:0] addr
);
  // add or subtract, wrapping at 32 bits
  assign addr = add ? 32'(base + offset) : 32'(base - offset);
endmodule // php_hint_addr
`default_nettype wire

// [sim/php_decoder_sva.sv]
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module php_decoder_sva
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // issue side
  input wire logic        INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] PC_VALUE,
  input wire logic [31:0] FIRST_SOURCE_VALUE,
  input wire logic [31:0] SECOND_SOURCE_VALUE,
  input wire logic        HAVE_MAIN_EXT,
  input wire logic        HAVE_DSP_EXT,
  // results and hints
  input wire logic        RESULT_VALID,
  input wire logic [31:0] RESULT_DATA,
  input wire logic        FLAGS_WRITE,
  input wire logic        FLAG_N,
  input wire logic        FLAG_Z,
  input wire logic        UNDEFINED,
  input wire logic        DATA_HINT_VALID,
  input wire logic [31:0] HINT_ADDR,
  input wire logic        HINT_READY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // field decodes of the issued word
  wire [15:0] hw2  = INSTR_WORD[15:0];
  wire        pk   = INSTR_VALID && INSTR_WORD[31:21] == php_pkg::OP_PACK;
  wire        pkok = pk && !INSTR_WORD[20] && !INSTR_WORD[4] && HAVE_DSP_EXT;
  wire        dpok = INSTR_VALID && HAVE_MAIN_EXT && INSTR_WORD[19:16] != 4'hf;
  wire        neg  = dpok && INSTR_WORD[31:20] == php_pkg::OP_DPL_NEG;
  wire        d12  = dpok && INSTR_WORD[31:20] == php_pkg::OP_DPL_POS && hw2[15:12] == 4'hf;
  wire        d8   = neg && hw2[15:8] == php_pkg::HW2_EIGHT_BIT_OFFSET;
  wire        dix  = neg && hw2[15:6] == php_pkg::HW2_INDEX;
  wire        lit  = INSTR_VALID && HAVE_MAIN_EXT && hw2[15:12] == 4'hf
                     && (INSTR_WORD[31:16] & php_pkg::LIT_MASK) == php_pkg::LIT_DATA;
  wire        orf  = INSTR_VALID && INSTR_WORD[31:21] == php_pkg::OP_OR_REG && INSTR_WORD[20];
  // expected addresses and pack halves
  wire [31:0] pcal = {PC_VALUE[31:2], 2'h0};
  wire [31:0] off  = {20'h0, hw2[11:0]};
  wire [31:0] a12  = FIRST_SOURCE_VALUE + off;
  wire [31:0] a8   = FIRST_SOURCE_VALUE - {24'h0, hw2[7:0]};
  wire [31:0] aix  = FIRST_SOURCE_VALUE + (SECOND_SOURCE_VALUE << hw2[5:4]);
  wire [31:0] alit = INSTR_WORD[23] ? pcal + off : pcal - off;
  wire        tbf  = hw2[5];
  wire [15:0] kept = tbf ? FIRST_SOURCE_VALUE[31:16] : FIRST_SOURCE_VALUE[15:0];
  wire        sgn  = SECOND_SOURCE_VALUE[31];

  chk_imm_add:
  assert property (d12 |=> DATA_HINT_VALID && HINT_ADDR == $past(a12))
    else $error("12-bit data hint address wrong");
  chk_neg_sub:
  assert property (d8 |=> DATA_HINT_VALID && HINT_ADDR == $past(a8))
    else $error("8-bit data hint address wrong");
  chk_index_add:
  assert property (dix |=> DATA_HINT_VALID && HINT_ADDR == $past(aix))
    else $error("index data hint address wrong");
  chk_literal_addr:
  assert property (lit |=> DATA_HINT_VALID && HINT_ADDR == $past(alit))
    else $error("literal data hint address wrong");
  chk_pack_undef:
  assert property (pk && (INSTR_WORD[20] || INSTR_WORD[4] || !HAVE_DSP_EXT)
                   |=> UNDEFINED && !RESULT_VALID && !FLAGS_WRITE)
    else $error("bad pack encoding not refused");
  chk_pack_halves:
  assert property (pkok |=> RESULT_VALID && !FLAGS_WRITE
                   && ($past(tbf) ? RESULT_DATA[31:16] : RESULT_DATA[15:0]) == $past(kept))
    else $error("pack halfword placement wrong");
  chk_top_zero:
  assert property (pkok && tbf && INSTR_WORD[14:12] == 3'h0 && hw2[7:6] == 2'h0
                   |=> RESULT_DATA[15:0] == {16{$past(sgn)}})
    else $error("top-first zero field not a full arithmetic shift");
  chk_main_ext:
  assert property (INSTR_VALID && !HAVE_MAIN_EXT && INSTR_WORD[31:20] == php_pkg::OP_DPL_POS
                   |=> UNDEFINED && !$rose(DATA_HINT_VALID))
    else $error("preload without main extension not refused");
  chk_flag_source:
  assert property (FLAGS_WRITE |-> $past(orf))
    else $error("flags written by wrong operation");
  chk_flags_nz:
  assert property (FLAGS_WRITE |-> RESULT_VALID && FLAG_N == RESULT_DATA[31]
                   && FLAG_Z == (RESULT_DATA == 32'h0))
    else $error("negative or zero flag wrong");
  chk_hint_hold:
  assert property (DATA_HINT_VALID && !HINT_READY && !INSTR_VALID
                   |=> DATA_HINT_VALID && $stable(HINT_ADDR))
    else $error("pending data hint not held");
endmodule // php_decoder_sva

bind php_decoder php_decoder_sva u_sva
(
  .CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
  .PC_VALUE(PC_VALUE), .FIRST_SOURCE_VALUE(FIRST_SOURCE_VALUE),
  .SECOND_SOURCE_VALUE(SECOND_SOURCE_VALUE), .HAVE_MAIN_EXT(HAVE_MAIN_EXT),
  .HAVE_DSP_EXT(HAVE_DSP_EXT), .RESULT_VALID(RESULT_VALID), .RESULT_DATA(RESULT_DATA),
  .FLAGS_WRITE(FLAGS_WRITE), .FLAG_N(FLAG_N), .FLAG_Z(FLAG_Z), .UNDEFINED(UNDEFINED),
  .DATA_HINT_VALID(DATA_HINT_VALID), .HINT_ADDR(HINT_ADDR), .HINT_READY(HINT_READY)
);
`default_nettype wire

// [sim/php_hint_mem.sv]
// memory-side model that takes or drops preload hints
`timescale 1ns/1ps
`default_nettype none
module php_hint_mem
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pace select and acceptance
  input  wire logic slow,
  output logic      ready
);
  logic [1:0] pace_q;  // slow-mode cycle count
  // ready every cycle, or one cycle in four when slow; hints are simply dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pace_q <= 2'h0;
      ready  <= 1'b0;
    end
    else
    begin
      pace_q <= pace_q + 2'h1;
      ready  <= !slow || pace_q == 2'h3;
    end
  end
endmodule // php_hint_mem
`default_nettype wire

// [sim/test_pack_halfword_and_preload_decode.sv]
// self-checking bench for the pack, or-tail and preload-hint decoder
`timescale 1ns/1ps
`default_nettype none
module test_pack_halfword_and_preload_decode;
  // one row: extensions, word, operands, status, dest, value, flags
  typedef struct packed
  {
    logic [1:0]  x;
    logic [31:0] w;
    logic [31:0] a;
    logic [31:0] b;
    logic [6:0]  s;
    logic [3:0]  d;
    logic [31:0] r;
    logic [2:0]  f;
  } php_row_s;
  logic        clk  = 1'b0;   // core clock
  logic        rst  = 1'b1;   // core reset
  logic        vld  = 1'b0;   // issue strobe
  logic [31:0] word = 32'h0;  // issued word
  logic [31:0] opa  = 32'h0;  // first source value
  logic [31:0] opb  = 32'h0;  // second source value
  logic [1:0]  ext  = 2'h3;   // main, dsp present
  logic        slow = 1'b0;   // partner pace
  logic        rv, fw, fn, fz, fc, cl, ud, up, dh, ih, rdy;
  logic [3:0]  dst;
  logic [31:0] rd, ha;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          k;
  wire  [6:0]  st = {cl, ud, up, rv, fw, dh, ih};  // status as a row holds it
  php_row_s    rows [0:21] = '{
    '{2'h3, 32'hea511203, 32'h80000000, 32'h10000001, 7'h4c, 4'h2, 32'h80000010, 3'h5},
    '{2'h3, 32'hea510253, 32'h00000000, 32'h00000001, 7'h4c, 4'h2, 32'h00000000, 3'h3},
    '{2'h3, 32'heac12203, 32'h11112222, 32'h00334400, 7'h48, 4'h2, 32'h33442222, 3'h0},
    '{2'h3, 32'heac10223, 32'h11112222, 32'h80005555, 7'h48, 4'h2, 32'h1111ffff, 3'h0},
    '{2'h3, 32'heac11223, 32'h11112222, 32'h00012340, 7'h48, 4'h2, 32'h11111234, 3'h0},
    '{2'h3, 32'head12203, 32'h11112222, 32'h00334400, 7'h60, 4'h0, 32'h0, 3'h0},
    '{2'h3, 32'heac12213, 32'h11112222, 32'h00334400, 7'h60, 4'h0, 32'h0, 3'h0},
    '{2'h3, 32'heac12d03, 32'h11112222, 32'h00334400, 7'h58, 4'hd, 32'h33442222, 3'h0},
    '{2'h2, 32'heac12203, 32'h11112222, 32'h00334400, 7'h60, 4'h0, 32'h0, 3'h0},
    '{2'h3, 32'hf891ffff, 32'h10000000, 32'h0, 7'h42, 4'h0, 32'h10000fff, 3'h0},
    '{2'h3, 32'hf811fcff, 32'h10000000, 32'h0, 7'h42, 4'h0, 32'h0fffff01, 3'h0},
    '{2'h3, 32'hf811f033, 32'h10000000, 32'h101, 7'h42, 4'h0, 32'h10000808, 3'h0},
    '{2'h3, 32'hf811f03d, 32'h10000000, 32'h101, 7'h52, 4'h0, 32'h10000808, 3'h0},
    '{2'h3, 32'hf89ff010, 32'h10000000, 32'h0, 7'h42, 4'h0, 32'h00001010, 3'h0},
    '{2'h3, 32'hf81ff010, 32'h10000000, 32'h0, 7'h42, 4'h0, 32'h00000ff0, 3'h0},
    '{2'h3, 32'hf991f123, 32'h10000000, 32'h0, 7'h41, 4'h0, 32'h10000123, 3'h0},
    '{2'h3, 32'hf911fc01, 32'h10000000, 32'h0, 7'h41, 4'h0, 32'h0fffffff, 3'h0},
    '{2'h3, 32'hf99ff004, 32'h10000000, 32'h0, 7'h41, 4'h0, 32'h00001004, 3'h0},
    '{2'h3, 32'hf911f013, 32'h10000000, 32'h101, 7'h41, 4'h0, 32'h10000202, 3'h0},
    '{2'h1, 32'hf891ffff, 32'h10000000, 32'h0, 7'h60, 4'h0, 32'h0, 3'h0},
    '{2'h3, 32'hea5f1203, 32'h10000000, 32'h0, 7'h00, 4'h0, 32'h0, 3'h0},
    '{2'h3, 32'h00000000, 32'h10000000, 32'h0, 7'h00, 4'h0, 32'h0, 3'h0}};

  // clock, 50 ns period
  always #25 clk = ~clk;

  // decoder under test
  php_decoder dut
  (
    .CLK(clk), .RST(rst), .INSTR_VALID(vld), .INSTR_WORD(word), .PC_VALUE(32'h00001003),
    .FIRST_SOURCE_VALUE(opa), .SECOND_SOURCE_VALUE(opb), .FLAG_C_IN(1'b0),
    .HAVE_MAIN_EXT(ext[1]), .HAVE_DSP_EXT(ext[0]), .RESULT_VALID(rv), .RESULT_DEST(dst),
    .RESULT_DATA(rd), .FLAGS_WRITE(fw), .FLAG_N(fn), .FLAG_Z(fz), .FLAG_C(fc),
    .CLAIMED(cl), .UNDEFINED(ud), .UNPREDICTABLE(up), .DATA_HINT_VALID(dh),
    .INSTR_HINT_VALID(ih), .HINT_ADDR(ha), .HINT_READY(rdy)
  );
  // memory side
  php_hint_mem u_mem (.clk(clk), .rst(rst), .slow(slow), .ready(rdy));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one instruction, answer looked at a cycle later
  task automatic issue(input logic [1:0] x, input logic [31:0] w, a, b);
    @(posedge clk);
    ext <= x;
    word <= w;
    opa <= a;
    opb <= b;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    @(negedge clk);
  endtask
  // hold reset, check outputs cleared, release on an edge
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk("reset status", 32'h0, {st, dst, fn, fz, fc});
    chk("reset values", 32'h0, rd | ha);
    @(posedge clk);
    rst <= 1'b0;
  endtask
  // verdict
  task automatic final_report;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // table, then hand-written cases
  initial
  begin
    do_reset(6);
    for (int i = 0; i < 22; i++)
    begin
      issue(rows[i].x, rows[i].w, rows[i].a, rows[i].b);
      chk("status", rows[i].s, st);
      if (rows[i].s[3])
        chk("dest", rows[i].d, dst);
      if (rows[i].s[3])
        chk("result", rows[i].r, rd);
      if (rows[i].s[2])
        chk("flags", rows[i].f, {fn, fz, fc});
      if (rows[i].s[1] | rows[i].s[0])
        chk("hint address", rows[i].r, ha);
    end
    chk("flags kept", 32'h3, {fn, fz, fc});
    slow <= 1'b1;
    @(posedge clk);
    word <= 32'hf891f010;
    opa <= 32'h30000000;
    vld <= 1'b1;
    @(posedge clk);
    word <= 32'hf991f020;
    @(posedge clk);
    vld <= 1'b0;
    @(negedge clk);
    chk("newer hint kind", 32'h1, {dh, ih});
    chk("newer hint address", 32'h30000020, ha);
    issue(2'h3, 32'hf891f00c, 32'h20000000, 32'h0);
    do_reset(2);
    issue(2'h3, 32'hf891f00c, 32'h20000000, 32'h0);
    k = 0;
    while (dh === 1'b1 && k < 8)
    begin
      chk("held address", 32'h2000000c, ha);
      @(negedge clk);
      k++;
    end
    chk("hint taken", 32'h0, {31'h0, dh});
    final_report();
  end
endmodule // test_pack_halfword_and_preload_decode
`default_nettype wire
